/* File: hw/ttls_pkg.sv */
// constants shared by the thread and load sequencer
package ttls_pkg;
    // gap counter figures, counted in half turns of the left reel
    localparam int GAP_W_DEF = 7;
    localparam logic [6:0] GAP_THREAD_DROP = 7'h04;
    localparam logic [6:0] GAP_TAPE_SEEN_LIMIT = 7'h0e;
    localparam logic [6:0] GAP_REELS_LIMIT_1 = 7'h18;
    localparam logic [6:0] GAP_RETRY_START = 7'h28;
    localparam logic [6:0] GAP_REELS_LIMIT_2 = 7'h38;
    localparam logic [6:0] GAP_BOT_LIMIT = 7'h50;
    localparam logic [6:0] GAP_ZERO = 7'h00;
    localparam logic [6:0] GAP_ONE = 7'h01;
    // sense byte bit positions
    localparam int SB7_LAMP = 0;
    localparam int SB7_LEFT_COL = 1;
    localparam int SB7_RIGHT_COL = 2;
    localparam int SB7_RESET_DOOR = 3;
    localparam int SB7_ERASE = 5;
    localparam int SB7_AIR = 6;
    localparam int SB6_WRITE_CUR = 1;
    localparam int SB18_POWER = 0;
    localparam logic [7:0] SENSE_RESET = 8'h00;
    // sequencer states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_THREAD = 8'h02,
        ST_REWRAP = 8'h04,
        ST_DROP = 8'h08,
        ST_COLUMNS = 8'h10,
        ST_LOADED = 8'h20,
        ST_READY = 8'h40,
        ST_SPARE = 8'h80
    } ttls_state_e;
endpackage

/* File: hw/ttls_rise.sv */
// rising edge pulse from a synchronous level
`timescale 1ns/1ps
module ttls_rise (
    input wire logic clk,
    input wire logic rst,
    input wire logic level,
    output logic pulse
);
    typedef struct packed {
        logic prev;
    } ttls_rise_s;
    ttls_rise_s s_r;
    ttls_rise_s s_nxt;

    // remember last level
    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = level;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // one cycle per low-to-high change
    assign pulse = level & ~s_r.prev;
endmodule

/* File: hw/ttls_sequencer.sv */
// thread and load sequencer with drive error sense bits
`timescale 1ns/1ps
module ttls_sequencer #(
    parameter int GAP_W = ttls_pkg::GAP_W_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load_pb,
    input wire logic start_pb,
    input wire logic cart_sensed,
    input wire logic cart_open_sw,
    input wire logic half_turn,
    input wire logic tape_at_photo,
    input wire logic reels_loaded_port,
    input wire logic bot_marker,
    input wire logic air_bearing_ok,
    input wire logic left_column_low_port,
    input wire logic right_column_low_port,
    input wire logic left_column_bottom_switch,
    input wire logic right_column_bottom_switch,
    input wire logic lamp_fail,
    input wire logic reset_door_n,
    input wire logic hub_air_fail,
    input wire logic supply_limit_fault,
    input wire logic cooling_air_fail,
    input wire logic erase_fault,
    input wire logic write_current_fault,
    input wire logic power_on_reset,
    input wire logic safety_bail,
    output logic load_sequence_latch,
    output logic window_motor,
    output logic thread_state,
    output logic transfer_valve,
    output logic left_reel_cw,
    output logic left_reel_ccw,
    output logic right_reel_cw,
    output logic right_reel_ccw,
    output logic cart_motor,
    output logic load_rewind,
    output logic rewind_op,
    output logic backward_state,
    output logic halt_left_reel_load,
    output logic halt_right_reel_load,
    output logic columns_loaded,
    output logic load_complete,
    output logic manual_state,
    output logic capstan_backward,
    output logic ready,
    output logic load_check,
    output logic emergency_motor_relay,
    output logic [GAP_W-1:0] gap_pulse_counter,
    output logic [7:0] sense_byte6,
    output logic [7:0] sense_byte7,
    output logic [7:0] sense_byte18
);
    // elaboration check: the package counts need seven bits, wider only costs flops
    if (GAP_W < 7 || GAP_W > 16) begin : g_gap_w_bad
        $error("ttls_sequencer: GAP_W must be 7..16");
    end

    typedef struct packed {
        ttls_pkg::ttls_state_e st;
        logic [GAP_W-1:0] gap;
        logic latch;
        logic thread;
        logic second;
        logic tape_seen;
        logic ready;
        logic load_check;
        logic bot_shot;
        logic [7:0] sb6;
        logic [7:0] sb7;
        logic [7:0] sb18;
    } ttls_seq_s;

    ttls_seq_s s_r;
    ttls_seq_s s_nxt;

    logic load_p;
    logic start_p;
    logic turn_p;
    logic bot_p;
    logic relay_ok;
    logic drive_fault;
    logic load_block;

    // button, reel and marker edges
    ttls_rise u_rise_load (.clk(clk), .rst(rst), .level(load_pb), .pulse(load_p));
    ttls_rise u_rise_start (.clk(clk), .rst(rst), .level(start_pb), .pulse(start_p));
    ttls_rise u_rise_turn (.clk(clk), .rst(rst), .level(half_turn), .pulse(turn_p));
    ttls_rise u_rise_bot (.clk(clk), .rst(rst), .level(bot_marker), .pulse(bot_p));

    // package counts are seven bits; GAP_W is never narrower, so this only pads
    function automatic logic [GAP_W-1:0] gw(input logic [6:0] v);
        gw = GAP_W'(v);
    endfunction

    // power or cooling trouble opens the reel relays
    assign relay_ok = ~(supply_limit_fault | cooling_air_fail);
    // every condition that knocks the drive out of ready
    assign drive_fault = left_column_bottom_switch | right_column_bottom_switch | lamp_fail
                       | ~reset_door_n | ~air_bearing_ok | hub_air_fail | ~relay_ok;
    // resets are momentary: they only block, nothing is remembered
    assign load_block = drive_fault | power_on_reset | safety_bail;

    // sequencer next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.bot_shot = 1'b0;
        // sense bits follow the drive lines each cycle, no latching
        s_nxt.sb7 = ttls_pkg::SENSE_RESET;
        s_nxt.sb6 = ttls_pkg::SENSE_RESET;
        s_nxt.sb18 = ttls_pkg::SENSE_RESET;
        s_nxt.sb7[ttls_pkg::SB7_LAMP] = lamp_fail;
        s_nxt.sb7[ttls_pkg::SB7_LEFT_COL] = left_column_bottom_switch;
        s_nxt.sb7[ttls_pkg::SB7_RIGHT_COL] = right_column_bottom_switch;
        s_nxt.sb7[ttls_pkg::SB7_RESET_DOOR] = ~reset_door_n;
        s_nxt.sb7[ttls_pkg::SB7_ERASE] = erase_fault;
        s_nxt.sb7[ttls_pkg::SB7_AIR] = ~air_bearing_ok | hub_air_fail;
        s_nxt.sb6[ttls_pkg::SB6_WRITE_CUR] = write_current_fault;
        s_nxt.sb18[ttls_pkg::SB18_POWER] = ~relay_ok;
        // gap counter advances on each half turn, saturating
        if (turn_p && s_r.gap != {GAP_W{1'b1}}) begin
            s_nxt.gap = s_r.gap + gw(ttls_pkg::GAP_ONE);
        end
        case (s_r.st)
            ttls_pkg::ST_IDLE: begin
                if (load_p && cart_sensed && !load_block) begin
                    s_nxt.st = ttls_pkg::ST_THREAD;
                    s_nxt.latch = 1'b1;
                    s_nxt.thread = 1'b1;
                    s_nxt.gap = gw(ttls_pkg::GAP_ZERO);
                    s_nxt.second = 1'b0;
                    s_nxt.tape_seen = 1'b0;
                    s_nxt.load_check = 1'b0;
                end
            end
            ttls_pkg::ST_THREAD: begin
                if (tape_at_photo) begin
                    s_nxt.tape_seen = 1'b1;
                end
                if (bot_p && reels_loaded_port) begin
                    // marker one-shot restarts the count
                    s_nxt.bot_shot = 1'b1;
                    s_nxt.gap = gw(ttls_pkg::GAP_ZERO);
                    s_nxt.st = ttls_pkg::ST_DROP;
                end else if (!s_r.second && s_r.gap >= gw(ttls_pkg::GAP_TAPE_SEEN_LIMIT)
                             && !s_r.tape_seen) begin
                    s_nxt.st = ttls_pkg::ST_REWRAP;
                end else if (!s_r.second && s_r.gap >= gw(ttls_pkg::GAP_REELS_LIMIT_1)
                             && !reels_loaded_port) begin
                    s_nxt.st = ttls_pkg::ST_REWRAP;
                end else if (s_r.second && s_r.gap >= gw(ttls_pkg::GAP_REELS_LIMIT_2)
                             && !reels_loaded_port) begin
                    // second failure: stop for good and light the check
                    s_nxt.load_check = 1'b1;
                    s_nxt.latch = 1'b0;
                    s_nxt.thread = 1'b0;
                    s_nxt.st = ttls_pkg::ST_IDLE;
                end else if (s_r.gap >= gw(ttls_pkg::GAP_BOT_LIMIT)) begin
                    // marker never came: operator must look at the tape
                    s_nxt.latch = 1'b0;
                    s_nxt.thread = 1'b0;
                    s_nxt.st = ttls_pkg::ST_IDLE;
                end
            end
            ttls_pkg::ST_REWRAP: begin
                // tape rewinds while the counter keeps running to the retry point
                if (s_r.gap >= gw(ttls_pkg::GAP_RETRY_START)) begin
                    s_nxt.second = 1'b1;
                    s_nxt.st = ttls_pkg::ST_THREAD;
                end
            end
            ttls_pkg::ST_DROP: begin
                if (s_r.gap >= gw(ttls_pkg::GAP_THREAD_DROP)) begin
                    s_nxt.thread = 1'b0;
                    s_nxt.st = ttls_pkg::ST_COLUMNS;
                end
            end
            ttls_pkg::ST_COLUMNS: begin
                if (left_column_low_port && right_column_low_port) begin
                    s_nxt.st = ttls_pkg::ST_LOADED;
                    s_nxt.latch = 1'b0;
                end
            end
            ttls_pkg::ST_LOADED: begin
                if (start_p && !drive_fault) begin
                    s_nxt.ready = 1'b1;
                    s_nxt.st = ttls_pkg::ST_READY;
                end
            end
            ttls_pkg::ST_READY: begin
                if (drive_fault) begin
                    // held off until a fresh load sequence
                    s_nxt.ready = 1'b0;
                    s_nxt.st = ttls_pkg::ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ttls_pkg::ST_IDLE;
                s_nxt.latch = 1'b0;
                s_nxt.thread = 1'b0;
                s_nxt.ready = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '{st: ttls_pkg::ST_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // motor and solenoid drive from the registered state
    logic seq_run;
    assign seq_run = s_r.st == ttls_pkg::ST_THREAD || s_r.st == ttls_pkg::ST_DROP;
    assign load_sequence_latch = s_r.latch;
    assign window_motor = s_r.latch;
    assign thread_state = s_r.thread;
    assign transfer_valve = s_r.thread;
    // relays gate all reel drive, so a power check stops the reels
    assign left_reel_cw = relay_ok & s_r.latch & seq_run;
    assign left_reel_ccw = relay_ok & ((s_r.st == ttls_pkg::ST_COLUMNS && air_bearing_ok && !s_r.thread)
                         || s_r.st == ttls_pkg::ST_REWRAP);
    assign right_reel_cw = relay_ok & s_r.latch & (seq_run || s_r.st == ttls_pkg::ST_COLUMNS);
    assign right_reel_ccw = relay_ok & (s_r.st == ttls_pkg::ST_REWRAP);
    // opener stops on its own switch; without a cartridge it stays off
    assign cart_motor = s_r.latch & cart_sensed & ~cart_open_sw & (s_r.st == ttls_pkg::ST_THREAD);
    assign load_rewind = s_r.bot_shot;
    assign rewind_op = s_r.bot_shot;
    assign backward_state = s_r.bot_shot;
    assign halt_left_reel_load = (s_r.st == ttls_pkg::ST_LOADED || s_r.st == ttls_pkg::ST_READY)
                               & left_column_low_port;
    assign halt_right_reel_load = (s_r.st == ttls_pkg::ST_LOADED || s_r.st == ttls_pkg::ST_READY)
                                & right_column_low_port;
    assign columns_loaded = s_r.st == ttls_pkg::ST_LOADED || s_r.st == ttls_pkg::ST_READY;
    assign load_complete = columns_loaded;
    assign manual_state = ~columns_loaded;
    // column control back in hand: capstan backs tape onto the marker
    assign capstan_backward = relay_ok & (s_r.st == ttls_pkg::ST_LOADED) & ~bot_marker;
    assign ready = s_r.ready;
    assign load_check = s_r.load_check;
    assign emergency_motor_relay = relay_ok;
    assign gap_pulse_counter = s_r.gap;
    assign sense_byte6 = s_r.sb6;
    assign sense_byte7 = s_r.sb7;
    assign sense_byte18 = s_r.sb18;

    // checks on the sequencer
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_load_start;
        s_r.st == ttls_pkg::ST_IDLE && load_p && cart_sensed && !load_block;
    endsequence
    sequence s_latch_on;
        load_sequence_latch && window_motor && thread_state && transfer_valve;
    endsequence
    sequence s_marker_hit;
        s_r.st == ttls_pkg::ST_THREAD && bot_p && reels_loaded_port;
    endsequence

    a_load_sets_latch: assert property (s_load_start |=> s_latch_on)
        else $error("load press did not set the latch");
    a_thread_valve: assert property (thread_state == transfer_valve)
        else $error("valve differs from threading state");
    a_reels_forward: assert property (s_load_start ##1 relay_ok |-> left_reel_cw && right_reel_cw)
        else $error("reels not forward at start");
    a_opener_stops: assert property (cart_open_sw |-> !cart_motor)
        else $error("opener runs past open switch");
    a_gap_step: assert property (turn_p && !load_p && !bot_p
                                 && gap_pulse_counter != {GAP_W{1'b1}}
                                 |=> gap_pulse_counter == $past(gap_pulse_counter) + gw(ttls_pkg::GAP_ONE))
        else $error("gap counter missed a half turn");
    a_marker_shot: assert property (s_marker_hit |=> load_rewind && rewind_op && backward_state
                                    && gap_pulse_counter == gw(ttls_pkg::GAP_ZERO) ##1 !load_rewind)
        else $error("marker one-shot wrong");
    a_thread_drop: assert property (s_r.st == ttls_pkg::ST_DROP && gap_pulse_counter >= gw(ttls_pkg::GAP_THREAD_DROP)
                                    |=> !thread_state)
        else $error("threading state held past count four");
    // a rewind onto the file reel also runs the left reel backward, threading still set
    a_left_reverse: assert property (left_reel_ccw |-> relay_ok
                                     && (!thread_state && air_bearing_ok || right_reel_ccw))
        else $error("left reel reversed while threading");
    a_cols_loaded: assert property (s_r.st == ttls_pkg::ST_COLUMNS && left_column_low_port && right_column_low_port
                                    |=> load_complete && !manual_state)
        else $error("columns loaded not reported");
    a_start_ready: assert property (s_r.st == ttls_pkg::ST_LOADED && start_p && !drive_fault |=> ready)
        else $error("start did not set ready");
    a_sense_follow: assert property (##1 sense_byte7[ttls_pkg::SB7_RESET_DOOR] == $past(~reset_door_n)
                                     && sense_byte7[ttls_pkg::SB7_LAMP] == $past(lamp_fail))
        else $error("sense byte 7 not following drive lines");
    a_relay_drop: assert property (supply_limit_fault |-> !emergency_motor_relay && !left_reel_cw
                                   && !right_reel_cw)
        else $error("motor control kept under power check");
    a_fault_ready: assert property (ready && drive_fault |=> !ready ##1 !ready)
        else $error("ready survived a drive fault");
    a_retry_check: assert property (s_r.st == ttls_pkg::ST_THREAD && s_r.second && !bot_p
                                    && gap_pulse_counter >= gw(ttls_pkg::GAP_REELS_LIMIT_2)
                                    && !reels_loaded_port |=> load_check)
        else $error("second failure left no load check");
    // reel halts, capstan and sense copies against the state that owns them
    a_halt_ports: assert property (columns_loaded |-> halt_left_reel_load == left_column_low_port
                                   && halt_right_reel_load == right_column_low_port)
        else $error("reel-load halts not following the low ports");
    a_capstan_back: assert property (capstan_backward |-> load_complete && !manual_state
                                     && emergency_motor_relay)
        else $error("capstan backing tape outside column control");
    a_blocked_load: assert property (s_r.st == ttls_pkg::ST_IDLE && load_p && (power_on_reset || safety_bail)
                                     |=> !load_sequence_latch)
        else $error("load started during a reset condition");
    a_air_sense: assert property (##1 sense_byte7[ttls_pkg::SB7_AIR] == $past(~air_bearing_ok | hub_air_fail))
        else $error("air failure not in sense byte 7");
    a_write_sense: assert property (##1 sense_byte6[ttls_pkg::SB6_WRITE_CUR] == $past(write_current_fault))
        else $error("write current fault not in sense byte 6");
    a_loaded_first: assert property (load_rewind |-> $past(reels_loaded_port))
        else $error("marker taken before reels were loaded");
endmodule

/* File: sim/test_tape_thread_load_sequencer.sv */
// self-checking bench for the thread and load sequencer
`timescale 1ns/1ps
module test_tape_thread_load_sequencer;
    logic clk, rst, load_pb, start_pb, cart_sensed, wrap_ok, lamp_fail, reset_door_n, hub_air_fail;
    logic supply_limit_fault, cooling_air_fail, erase_fault, write_current_fault, power_on_reset, safety_bail;
    logic air_bearing_ok, left_column_bottom_switch, right_column_bottom_switch, ht_q, mk_q;
    logic half_turn, cart_open_sw, tape_at_photo, reels_loaded_port, bot_marker;
    logic left_column_low_port, right_column_low_port, load_sequence_latch, window_motor, thread_state;
    logic transfer_valve, left_reel_cw, left_reel_ccw, right_reel_cw, right_reel_ccw, cart_motor, load_rewind;
    logic rewind_op, backward_state, halt_left_reel_load, halt_right_reel_load, columns_loaded, load_complete;
    logic manual_state, capstan_backward, ready, load_check, emergency_motor_relay;
    logic [6:0] gap_pulse_counter;
    logic [7:0] sense_byte6, sense_byte7, sense_byte18;
    int err_total, tests_run, exp_gap, n;
    int drop_bits [8] = '{0, 1, 2, 3, 4, 6, 7, 9};
    ttls_sequencer #(.GAP_W(7)) ttls_sequencer_inst (.clk, .rst, .load_pb, .start_pb, .cart_sensed,
        .cart_open_sw, .half_turn, .tape_at_photo, .reels_loaded_port, .bot_marker, .air_bearing_ok,
        .left_column_low_port, .right_column_low_port, .left_column_bottom_switch, .right_column_bottom_switch,
        .lamp_fail, .reset_door_n, .hub_air_fail, .supply_limit_fault, .cooling_air_fail, .erase_fault,
        .write_current_fault, .power_on_reset, .safety_bail, .load_sequence_latch, .window_motor, .thread_state,
        .transfer_valve, .left_reel_cw, .left_reel_ccw, .right_reel_cw, .right_reel_ccw, .cart_motor,
        .load_rewind, .rewind_op, .backward_state, .halt_left_reel_load, .halt_right_reel_load, .columns_loaded,
        .load_complete, .manual_state, .capstan_backward, .ready, .load_check, .emergency_motor_relay,
        .gap_pulse_counter, .sense_byte6, .sense_byte7, .sense_byte18);
    ttls_drive_model ttls_drive_model_inst (.clk, .rst, .wrap_ok, .load_sequence_latch, .left_reel_cw,
        .left_reel_ccw, .cart_motor, .half_turn, .cart_open_sw, .tape_at_photo, .reels_loaded_port, .bot_marker,
        .left_column_low_port, .right_column_low_port);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // reference gap count: one step per photocell rise, cleared by an accepted marker
    always @(posedge clk) begin
        ht_q <= half_turn;
        mk_q <= bot_marker;
        if (half_turn && !ht_q) exp_gap <= exp_gap + 1;
        if (bot_marker && !mk_q && reels_loaded_port) exp_gap <= 0;
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s is %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic press(input bit is_start);
        @(posedge clk);
        if (is_start) start_pb <= 1'b1;
        else load_pb <= 1'b1;
        @(posedge clk);
        start_pb <= 1'b0;
        load_pb <= 1'b0;
        #1;
    endtask
    // bits: lamp, left, right, key/door, hub, erase, bearing, supply, write, cooling, power-on, bail
    task automatic set_faults(input logic [11:0] f);
        @(posedge clk);
        lamp_fail <= f[0];
        left_column_bottom_switch <= f[1];
        right_column_bottom_switch <= f[2];
        reset_door_n <= !f[3];
        hub_air_fail <= f[4];
        erase_fault <= f[5];
        air_bearing_ok <= !f[6];
        supply_limit_fault <= f[7];
        write_current_fault <= f[8];
        cooling_air_fail <= f[9];
        power_on_reset <= f[10];
        safety_bail <= f[11];
    endtask
    task automatic check_sense(input logic [11:0] f);
        tick();
        chk_val(sense_byte7, {1'h0, f[6] | f[4], f[5], 1'h0, f[3:0]}, "byte7");
        chk_val(sense_byte6, {6'h00, f[8], 1'h0}, "byte6");
        chk_val(sense_byte18, {7'h00, f[7] | f[9]}, "byte18");
        chk_bit(emergency_motor_relay, !(f[7] | f[9]), "relay");
    endtask
    task automatic do_load();
        press(1'b0);
        exp_gap = 0;
        chk_bit(load_sequence_latch & window_motor, 1'b1, "latch and window");
        chk_bit(thread_state & transfer_valve, 1'b1, "thread and valve");
        chk_bit(left_reel_cw & right_reel_cw, 1'b1, "reels forward");
        chk_bit(load_check, 1'b0, "check cleared on start");
        chk_bit(cart_motor, !cart_open_sw, "opener running");
        for (n = 0; n < 40 && cart_open_sw !== 1'b1; n++) tick();
        chk_bit(cart_motor, 1'b0, "opener stopped");
        for (n = 0; n < 400 && bot_marker !== 1'b1; n++) tick();
        for (n = 0; n < 4 && load_rewind !== 1'b1; n++) tick();
        chk_bit(load_rewind & rewind_op & backward_state & left_reel_cw, 1'b1, "marker shot");
        chk_val({1'h0, gap_pulse_counter}, 8'h00, "gap after marker");
        tick();
        chk_bit(load_rewind, 1'b0, "shot length");
        for (n = 0; n < 200 && thread_state !== 1'b0; n++) tick();
        chk_val({1'h0, gap_pulse_counter}, 8'(exp_gap), "gap count");
        chk_val({1'h0, gap_pulse_counter}, {1'h0, ttls_pkg::GAP_THREAD_DROP}, "thread drop count");
        chk_bit(transfer_valve, 1'b0, "valve off");
        tick();
        chk_bit(left_reel_ccw & right_reel_cw & !left_reel_cw, 1'b1, "left reel reversed");
        for (n = 0; n < 200 && load_complete !== 1'b1; n++) tick();
        chk_bit(halt_left_reel_load & halt_right_reel_load, 1'b1, "halts");
        chk_bit(columns_loaded & !manual_state & !load_sequence_latch, 1'b1, "complete");
        chk_bit(capstan_backward, 1'b1, "capstan back");
    endtask
    initial begin
        {load_pb, start_pb, wrap_ok, lamp_fail, hub_air_fail, supply_limit_fault} = '0;
        {cooling_air_fail, erase_fault, write_current_fault, power_on_reset, safety_bail} = '0;
        {left_column_bottom_switch, right_column_bottom_switch, err_total, tests_run, exp_gap} = '0;
        {cart_sensed, reset_door_n, air_bearing_ok, rst} = 4'h7;
        n = $urandom(32'h651b_fff4);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        tick();
        chk_bit(load_sequence_latch | ready | load_check | !manual_state, 1'b0, "reset state");
        chk_val(sense_byte7 | sense_byte6 | sense_byte18, 8'h00, "reset sense");
        // presses that must be ignored: no cartridge, then bail tripped
        @(posedge clk);
        cart_sensed <= 1'b0;
        press(1'b0);
        chk_bit(load_sequence_latch, 1'b0, "no cartridge");
        set_faults(12'h800);
        cart_sensed <= 1'b1;
        press(1'b0);
        chk_bit(load_sequence_latch, 1'b0, "bail blocks");
        for (int i = 0; i < 24; i++) begin
            n = $urandom();
            set_faults(12'(n));
            check_sense(12'(n));
        end
        // tape never wraps: one retry, then load check held until the next load press
        set_faults(12'h000);
        tick();
        press(1'b0);
        exp_gap = 0;
        for (n = 0; n < 1000 && right_reel_ccw !== 1'b1; n++) tick();
        chk_val({1'h0, gap_pulse_counter}, {1'h0, ttls_pkg::GAP_TAPE_SEEN_LIMIT}, "first check");
        chk_bit(left_reel_ccw & right_reel_ccw, 1'b1, "rewind to file reel");
        for (n = 0; n < 1000 && load_check !== 1'b1; n++) tick();
        chk_val({1'h0, gap_pulse_counter}, {1'h0, ttls_pkg::GAP_REELS_LIMIT_2}, "second check");
        chk_val({1'h0, gap_pulse_counter}, 8'(exp_gap), "retry gap");
        chk_bit(load_sequence_latch, 1'b0, "latch after check");
        wrap_ok <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            set_faults(12'h000);
            do_load();
            press(1'b1);
            chk_bit(ready, 1'b1, "ready on start");
            set_faults(12'(1 << drop_bits[i]));
            check_sense(12'(1 << drop_bits[i]));
            chk_bit(ready, 1'b0, "ready dropped");
            set_faults(12'h000);
            tick();
            press(1'b1);
            chk_bit(ready, 1'b0, "ready held off");
        end
        tally_and_finish();
    end
    // watchdog well beyond the longest expected run
    initial begin
        #(8 * 30000);
        err_total++;
        $display("unexpected at %0t: run took too long", $time);
        tally_and_finish();
    end
endmodule

/* File: sim/ttls_drive_model.sv */
// drive side model: reel photocell, cartridge opener, sensing port, marker and column ports
`timescale 1ns/1ps
module ttls_drive_model #(
    parameter int HALF_CYC = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wrap_ok,
    input wire logic load_sequence_latch,
    input wire logic left_reel_cw,
    input wire logic left_reel_ccw,
    input wire logic cart_motor,
    output logic half_turn,
    output logic cart_open_sw,
    output logic tape_at_photo,
    output logic reels_loaded_port,
    output logic bot_marker,
    output logic left_column_low_port,
    output logic right_column_low_port
);
    int ph;
    int fwd;
    int rev;
    int opn;
    // photocell toggles only while the left reel turns, so a stalled reel gives no counts
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ph <= 0;
            fwd <= 0;
            rev <= 0;
            opn <= 0;
            half_turn <= 1'b0;
        end else begin
            if (left_reel_cw || left_reel_ccw) begin
                ph <= (ph == HALF_CYC - 1) ? 0 : ph + 1;
                if (ph == HALF_CYC - 1) begin
                    half_turn <= !half_turn;
                    if (!half_turn && left_reel_cw) fwd <= fwd + 1;
                    if (!half_turn && left_reel_ccw) rev <= rev + 1;
                end
            end
            if (!load_sequence_latch) fwd <= 0;
            if (left_reel_cw) rev <= 0;
            if (cart_motor) opn <= opn + 1;
        end
    end
    // opener never closes again in this model, later loads see it open
    assign cart_open_sw = opn >= 6;
    assign tape_at_photo = wrap_ok && fwd >= 2;
    assign reels_loaded_port = wrap_ok && fwd >= 6;
    assign bot_marker = wrap_ok && fwd == 10;
    assign left_column_low_port = rev >= 3;
    assign right_column_low_port = rev >= 3;
endmodule
